/* pkg/fcd_pkg.sv */
/*
  Shared constants for the four-channel word mover: region decode, channel
  count, trigger selects and word layout.
  Assumes a flat 32-bit byte address map shared by all memory targets.
*/
package fcd_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH = 16;
  // Region decode on the top address byte
  localparam logic [7:0] REG_PMEM = 8'h00;
  localparam logic [7:0] REG_DMEM = 8'h80;
  localparam logic [7:0] REG_PERIPH = 8'h01;
  localparam logic [7:0] EXT_LO = 8'h02;
  localparam logic [7:0] EXT_HI = 8'h7F;
  // Trigger select per channel
  localparam logic [1:0] TRIG_NONE = 2'h0;
  localparam logic [1:0] TRIG_SER_RX = 2'h1;
  localparam logic [1:0] TRIG_SER_TX = 2'h2;
  localparam logic [1:0] TRIG_TIMER = 2'h3;
  // Target codes on the dedicated bus
  localparam logic [1:0] TGT_PMEM = 2'h0;
  localparam logic [1:0] TGT_DMEM = 2'h1;
  localparam logic [1:0] TGT_EXT = 2'h2;
  localparam logic [1:0] TGT_BAD = 2'h3;
  localparam logic [3:0] BE_WORD = 4'hF;
  localparam logic [ADDR_W-1:0] BOOT_SRC = 32'h0200_0000;
  localparam logic [ADDR_W-1:0] BOOT_DST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] BOOT_WORDS = 16'h0100;
  localparam logic [CH_W-1:0] BOOT_CH = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;

  typedef enum logic [1:0] {
    FCD_IDLE = 2'b00,
    FCD_READ = 2'b01,
    FCD_WRITE = 2'b11,
    FCD_BOOT = 2'b10
  } fcd_state_t;
endpackage : fcd_pkg

/* hw/fcd_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fcd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : fcd_fifo

/* hw/fcd_dma.sv */
/*
  Four-channel word mover on its own address/data bus, with boot copy.
  Assumes one-word targets answering with rd_valid_i / wr_ack_i, and
  channel setup presented on plain ports by the processor side.
*/
`timescale 1ns/1ps
module fcd_dma #(
  parameter int NCH = fcd_pkg::NUM_CH,
  parameter int DEPTH = fcd_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic boot_pin_i,
  input wire logic pmem_plain_mode_i,
  input wire logic dmem_cache_i,
  input wire logic [NCH-1:0] cfg_load_i,
  input wire logic [fcd_pkg::ADDR_W-1:0] cfg_src_i,
  input wire logic [fcd_pkg::ADDR_W-1:0] cfg_dst_i,
  input wire logic [fcd_pkg::CNT_W-1:0] cfg_count_i,
  input wire logic [1:0] cfg_trig_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [1:0] ser_rx_evt_i,
  input wire logic [1:0] ser_tx_evt_i,
  input wire logic [1:0] timer_evt_i,
  output logic bus_rd_o,
  output logic bus_wr_o,
  output logic [1:0] bus_tgt_o,
  output logic [fcd_pkg::ADDR_W-1:0] bus_addr_o,
  output logic [3:0] bus_be_o,
  output logic [fcd_pkg::WORD_W-1:0] bus_wdata_o,
  input wire logic [fcd_pkg::WORD_W-1:0] bus_rdata_i,
  input wire logic bus_rd_valid_i,
  input wire logic bus_wr_ack_i,
  output logic [NCH-1:0] ch_busy_o,
  output logic [NCH-1:0] ch_done_o,
  output logic [NCH-1:0] ch_err_o,
  output logic boot_done_o
);
  logic [fcd_pkg::ADDR_W-1:0] src_reg [NCH];
  logic [fcd_pkg::ADDR_W-1:0] dst_reg [NCH];
  logic [fcd_pkg::CNT_W-1:0] cnt_reg [NCH];
  logic [1:0] trig_reg [NCH];
  logic [3:0] be_reg [NCH];
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] busy_reg;
  logic [NCH-1:0] done_reg;
  logic [NCH-1:0] err_reg;
  fcd_pkg::fcd_state_t state_reg;
  logic [fcd_pkg::CH_W-1:0] cur_reg;
  logic boot_seen_reg;
  logic boot_pend_reg;
  logic boot_done_reg;
  logic rd_reg;
  logic wr_reg;
  logic [1:0] tgt_reg;
  logic [fcd_pkg::ADDR_W-1:0] addr_reg;
  logic [3:0] be_out_reg;
  logic [fcd_pkg::WORD_W-1:0] wdata_reg;

  // Region decode; peripheral space and top bytes above 8'h80 map to bad
  function automatic logic [1:0] region(input logic [fcd_pkg::ADDR_W-1:0] a);
    logic [7:0] top;
    top = a[fcd_pkg::ADDR_W-1 -: 8];
    if (top == fcd_pkg::REG_PMEM) begin
      region = fcd_pkg::TGT_PMEM;
    end else if (top == fcd_pkg::REG_DMEM) begin
      region = fcd_pkg::TGT_DMEM;
    end else if (top >= fcd_pkg::EXT_LO && top <= fcd_pkg::EXT_HI) begin
      region = fcd_pkg::TGT_EXT;
    end else begin
      region = fcd_pkg::TGT_BAD;
    end
  endfunction : region

  function automatic logic trig_hit(input logic [1:0] sel, input logic [1:0] rx,
                                    input logic [1:0] tx, input logic [1:0] tm);
    case (sel)
      fcd_pkg::TRIG_NONE: trig_hit = 1'b1;
      fcd_pkg::TRIG_SER_RX: trig_hit = |rx;
      fcd_pkg::TRIG_SER_TX: trig_hit = |tx;
      fcd_pkg::TRIG_TIMER: trig_hit = |tm;
      default: trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  // Fetched words wait here between the read and the write of one grant; reads and writes never overlap
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [fcd_pkg::WORD_W-1:0] fifo_out_data;
  fcd_fifo #(.WIDTH(fcd_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(bus_rd_valid_i && state_reg == fcd_pkg::FCD_READ),
    .in_ready_o(fifo_in_ready),
    .in_data_i(bus_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // Grant: eligible channel with lowest index
  wire [NCH-1:0] want = busy_reg & pend_reg;
  logic [fcd_pkg::CH_W-1:0] grant_idx;
  logic grant_any;
  always_comb begin
    grant_idx = '0;
    grant_any = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (want[i]) begin
        grant_idx = i[fcd_pkg::CH_W-1:0];
        grant_any = 1'b1;
      end
    end
  end

  wire [1:0] g_src_tgt = region(src_reg[grant_idx]);
  wire [1:0] g_dst_tgt = region(dst_reg[grant_idx]);
  wire g_illegal = (g_src_tgt == fcd_pkg::TGT_PMEM) || (g_src_tgt == fcd_pkg::TGT_BAD) ||
                   (g_dst_tgt == fcd_pkg::TGT_BAD) ||
                   (g_dst_tgt == fcd_pkg::TGT_PMEM && !pmem_plain_mode_i) ||
                   (dmem_cache_i && (g_src_tgt == fcd_pkg::TGT_DMEM ||
                                     g_dst_tgt == fcd_pkg::TGT_DMEM));
  // Narrow lanes only reach the external port; internal targets take words
  wire [1:0] c_dst_tgt = region(dst_reg[cur_reg]);
  wire [3:0] c_be = (c_dst_tgt == fcd_pkg::TGT_EXT) ? be_reg[cur_reg] : fcd_pkg::BE_WORD;
  wire start_rd = state_reg == fcd_pkg::FCD_IDLE && grant_any && !g_illegal && fifo_in_ready;
  wire start_bad = state_reg == fcd_pkg::FCD_IDLE && grant_any && g_illegal;
  wire rd_done = state_reg == fcd_pkg::FCD_READ && bus_rd_valid_i;
  wire wr_done = state_reg == fcd_pkg::FCD_WRITE && bus_wr_ack_i;
  wire wr_issue = state_reg == fcd_pkg::FCD_WRITE && !wr_reg && fifo_out_valid;
  assign fifo_pop = wr_done;
  wire [fcd_pkg::CNT_W-1:0] cnt_dec = cnt_reg[cur_reg] - fcd_pkg::CNT_STEP;
  wire boot_start = boot_pend_reg && state_reg == fcd_pkg::FCD_IDLE;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= fcd_pkg::FCD_IDLE;
      cur_reg <= '0;
    end else begin
      case (state_reg)
        fcd_pkg::FCD_IDLE: begin
          if (boot_start) begin
            state_reg <= fcd_pkg::FCD_BOOT;
          end else if (start_rd) begin
            state_reg <= fcd_pkg::FCD_READ;
            cur_reg <= grant_idx;
          end
        end
        fcd_pkg::FCD_READ: if (rd_done) state_reg <= fcd_pkg::FCD_WRITE;
        fcd_pkg::FCD_WRITE: if (wr_done) state_reg <= fcd_pkg::FCD_IDLE;
        fcd_pkg::FCD_BOOT: state_reg <= fcd_pkg::FCD_IDLE;
        default: state_reg <= fcd_pkg::FCD_IDLE;
      endcase
    end
  end

  // Boot strap caught on the first clock after reset release
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      boot_seen_reg <= 1'b0;
      boot_pend_reg <= 1'b0;
      boot_done_reg <= 1'b0;
    end else begin
      if (!boot_seen_reg) begin
        boot_seen_reg <= 1'b1;
        boot_pend_reg <= boot_pin_i;
      end else if (boot_start) begin
        boot_pend_reg <= 1'b0;
      end
      if (boot_seen_reg && !boot_pend_reg && !busy_reg[fcd_pkg::BOOT_CH]) begin
        boot_done_reg <= 1'b1;
      end
    end
  end

  // Per-channel state; one word per grant lets a lower-index channel take the bus between words
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      busy_reg <= '0;
      done_reg <= '0;
      err_reg <= '0;
      pend_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        src_reg[i] <= '0;
        dst_reg[i] <= '0;
        cnt_reg[i] <= '0;
        trig_reg[i] <= fcd_pkg::TRIG_NONE;
        be_reg[i] <= fcd_pkg::BE_WORD;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // Trigger sets pending; consumption clears it unless a new one arrives
        if (trig_hit(trig_reg[i], ser_rx_evt_i, ser_tx_evt_i, timer_evt_i)) begin
          pend_reg[i] <= 1'b1;
        end else if (start_rd && grant_idx == i[fcd_pkg::CH_W-1:0]) begin
          pend_reg[i] <= 1'b0;
        end
        if (cfg_load_i[i] && !busy_reg[i]) begin
          src_reg[i] <= cfg_src_i;
          dst_reg[i] <= cfg_dst_i;
          cnt_reg[i] <= cfg_count_i;
          trig_reg[i] <= cfg_trig_i;
          be_reg[i] <= cfg_be_i;
          pend_reg[i] <= (cfg_trig_i == fcd_pkg::TRIG_NONE); // Old mode's trigger must not leak
          busy_reg[i] <= (cfg_count_i != fcd_pkg::CNT_ZERO);
          done_reg[i] <= (cfg_count_i == fcd_pkg::CNT_ZERO);
          err_reg[i] <= 1'b0;
        end
      end
      if (boot_start) begin
        src_reg[fcd_pkg::BOOT_CH] <= fcd_pkg::BOOT_SRC;
        dst_reg[fcd_pkg::BOOT_CH] <= fcd_pkg::BOOT_DST;
        cnt_reg[fcd_pkg::BOOT_CH] <= fcd_pkg::BOOT_WORDS;
        trig_reg[fcd_pkg::BOOT_CH] <= fcd_pkg::TRIG_NONE;
        be_reg[fcd_pkg::BOOT_CH] <= fcd_pkg::BE_WORD;
        busy_reg[fcd_pkg::BOOT_CH] <= 1'b1;
        done_reg[fcd_pkg::BOOT_CH] <= 1'b0;
      end
      if (start_bad) begin
        busy_reg[grant_idx] <= 1'b0;
        err_reg[grant_idx] <= 1'b1;
      end
      if (wr_done) begin
        src_reg[cur_reg] <= src_reg[cur_reg] + fcd_pkg::ADDR_STEP;
        dst_reg[cur_reg] <= dst_reg[cur_reg] + fcd_pkg::ADDR_STEP;
        cnt_reg[cur_reg] <= cnt_dec;
        if (cnt_dec == fcd_pkg::CNT_ZERO) begin
          busy_reg[cur_reg] <= 1'b0;
          done_reg[cur_reg] <= 1'b1;
        end
      end
    end
  end

  // Dedicated bus drivers, all registered
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      tgt_reg <= fcd_pkg::TGT_PMEM;
      addr_reg <= '0;
      be_out_reg <= fcd_pkg::BE_WORD;
      wdata_reg <= '0;
    end else if (start_rd) begin
      rd_reg <= 1'b1;
      wr_reg <= 1'b0;
      tgt_reg <= g_src_tgt;
      addr_reg <= src_reg[grant_idx];
      be_out_reg <= fcd_pkg::BE_WORD;
    end else if (wr_issue) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b1;
      tgt_reg <= c_dst_tgt;
      addr_reg <= dst_reg[cur_reg];
      be_out_reg <= c_be;
      wdata_reg <= fifo_out_data;
    end else if (rd_done || wr_done) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
  end

  assign bus_rd_o = rd_reg;
  assign bus_wr_o = wr_reg;
  assign bus_tgt_o = tgt_reg;
  assign bus_addr_o = addr_reg;
  assign bus_be_o = be_out_reg;
  assign bus_wdata_o = wdata_reg;
  assign ch_busy_o = busy_reg;
  assign ch_done_o = done_reg;
  assign ch_err_o = err_reg;
  assign boot_done_o = boot_done_reg;
endmodule : fcd_dma

/* tb/fcd_dma_monitor.sv */
/* Checker on fcd_dma ports: bus legality, handshakes and status.
   Assumes a bind to fcd_dma, one clock and a synchronous reset. */
`timescale 1ns/1ps
module fcd_dma_monitor #(
  parameter int NCH = 4
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic pmem_plain_mode_i,
  input wire logic dmem_cache_i,
  input wire logic bus_rd_o,
  input wire logic bus_wr_o,
  input wire logic [1:0] bus_tgt_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [3:0] bus_be_o,
  input wire logic [31:0] bus_wdata_o,
  input wire logic [31:0] bus_rdata_i,
  input wire logic bus_rd_valid_i,
  input wire logic bus_wr_ack_i,
  input wire logic [NCH-1:0] ch_busy_o,
  input wire logic [NCH-1:0] ch_done_o,
  input wire logic boot_done_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_PMEM_NO_RD: assert property (bus_rd_o |-> bus_tgt_o != fcd_pkg::TGT_PMEM)
    else $error("read from program memory");
  AST_RD_FULL: assert property (bus_rd_o |-> bus_be_o == fcd_pkg::BE_WORD)
    else $error("narrow read");
  AST_NO_BAD_TGT: assert property ((bus_rd_o || bus_wr_o) |-> bus_tgt_o != fcd_pkg::TGT_BAD)
    else $error("illegal target");
  AST_NO_CACHE: assert property ((bus_rd_o || bus_wr_o) && bus_tgt_o == fcd_pkg::TGT_DMEM
    |-> !dmem_cache_i) else $error("access to cached memory");
  AST_PMEM_PLAIN: assert property (bus_wr_o && bus_tgt_o == fcd_pkg::TGT_PMEM
    |-> pmem_plain_mode_i) else $error("program write outside plain mode");
  AST_RD_HOLD: assert property (bus_rd_o && !bus_rd_valid_i
    |=> bus_rd_o && $stable(bus_addr_o)) else $error("read dropped early");
  AST_RD_THEN_WR: assert property (bus_rd_o && bus_rd_valid_i |=> !bus_rd_o && !bus_wr_o
    ##1 bus_wr_o && bus_wdata_o == $past(bus_rdata_i, 2)) else $error("write data differs from read");
  AST_WR_HOLD: assert property (bus_wr_o && !bus_wr_ack_i
    |=> bus_wr_o && $stable(bus_wdata_o)) else $error("write dropped early");
  AST_ONE_WORD: assert property (bus_wr_o && bus_wr_ack_i |=> !bus_wr_o && !bus_rd_o)
    else $error("more than one word per grant");
  AST_DONE_IDLE: assert property ((ch_done_o & ch_busy_o) == 0)
    else $error("done while busy");
  cover property (bus_wr_o && bus_tgt_o == fcd_pkg::TGT_PMEM);
  cover property (bus_rd_o && bus_tgt_o == fcd_pkg::TGT_EXT);
  cover property ($rose(boot_done_o));
endmodule : fcd_dma_monitor
bind fcd_dma fcd_dma_monitor #(.NCH(NCH)) mon_u (.sys_clk_i, .sys_rst_i, .pmem_plain_mode_i,
  .dmem_cache_i, .bus_rd_o, .bus_wr_o, .bus_tgt_o, .bus_addr_o, .bus_be_o, .bus_wdata_o,
  .bus_rdata_i, .bus_rd_valid_i, .bus_wr_ack_i, .ch_busy_o, .ch_done_o, .boot_done_o);

/* tb/fcd_mem_model.sv */
/* Memory side model: reads return an address pattern, writes merge lanes.
   Assumes one word in flight; the bench sets dly for slow answers. */
`timescale 1ns/1ps
module fcd_mem_model (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic rd_valid_o,
  output logic wr_ack_o
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rd_reg;
  logic [31:0] cur;
  int dly = 0;
  int cnt;
  // Idle cycles show the inverse so stale data never matches
  assign rdata_o = rd_valid_o ? rd_reg : ~rd_reg;
  always @(posedge sys_clk_i) begin
    rd_valid_o <= 1'h0;
    wr_ack_o <= 1'h0;
    if (sys_rst_i) begin
      cnt <= 0;
      rd_reg <= 32'h0000_0000;
    end else if ((rd_i || wr_i) && !rd_valid_o && !wr_ack_o) begin
      cnt <= (cnt < dly) ? cnt + 1 : 0;
      if (cnt >= dly && rd_i) begin
        rd_reg <= addr_i ^ 32'hC3C3_0000;
        rd_valid_o <= 1'h1;
      end else if (cnt >= dly) begin
        cur = mem.exists(addr_i) ? mem[addr_i] : 32'h0000_0000;
        for (int b = 0; b < 4; b++)
          if (be_i[b]) cur[8*b +: 8] = wdata_i[8*b +: 8];
        mem[addr_i] = cur;
        wr_ack_o <= 1'h1;
      end
    end
  end
endmodule : fcd_mem_model

/* tb/fcd_dma_tb.sv */
/* Self-checking bench for fcd_dma and its FIFO, with a memory model.
   Assumes fcd_pkg, design modules, monitor and model compiled first. */
`timescale 1ns/1ps
module fcd_dma_tb;
  logic sys_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic boot_pin_i = 1'h1;
  logic pmem_plain_mode_i = 1'h1;
  logic dmem_cache_i = 1'h0;
  logic [3:0] cfg_load_i = 4'h0;
  logic [31:0] cfg_src_i = 32'h0000_0000;
  logic [31:0] cfg_dst_i = 32'h0000_0000;
  logic [15:0] cfg_count_i = 16'h0000;
  logic [1:0] cfg_trig_i = 2'h0;
  logic [3:0] cfg_be_i = 4'hF;
  logic [1:0] ser_rx_evt_i = 2'h0;
  logic [1:0] ser_tx_evt_i = 2'h0;
  logic [1:0] timer_evt_i = 2'h0;
  logic bus_rd_o, bus_wr_o, bus_rd_valid_i, bus_wr_ack_i, boot_done_o;
  logic [1:0] bus_tgt_o;
  logic [3:0] bus_be_o, ch_busy_o, ch_done_o, ch_err_o;
  logic [31:0] bus_addr_o, bus_wdata_o, bus_rdata_i;
  logic cache_v = 1'h0;
  logic plain_v = 1'h1;
  logic [3:0] be_v = 4'hF;
  int mismatches = 0;
  int total_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  fcd_dma dut_u (.sys_clk_i, .sys_rst_i, .boot_pin_i, .pmem_plain_mode_i, .dmem_cache_i,
    .cfg_load_i, .cfg_src_i, .cfg_dst_i, .cfg_count_i, .cfg_trig_i, .cfg_be_i, .ser_rx_evt_i,
    .ser_tx_evt_i, .timer_evt_i, .bus_rd_o, .bus_wr_o, .bus_tgt_o, .bus_addr_o, .bus_be_o,
    .bus_wdata_o, .bus_rdata_i, .bus_rd_valid_i, .bus_wr_ack_i, .ch_busy_o, .ch_done_o,
    .ch_err_o, .boot_done_o);
  fcd_mem_model mem_u (.sys_clk_i, .sys_rst_i, .rd_i(bus_rd_o), .wr_i(bus_wr_o),
    .addr_i(bus_addr_o), .be_i(bus_be_o), .wdata_i(bus_wdata_o), .rdata_o(bus_rdata_i),
    .rd_valid_o(bus_rd_valid_i), .wr_ack_o(bus_wr_ack_i));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Setup on the plain ports: full 32-bit addresses, a 16-bit count and the lane enables from be_v
  task automatic load(input int ch, input logic [31:0] s, d, input logic [15:0] n,
                      input logic [1:0] tr);
    @(posedge sys_clk_i);
    cfg_src_i <= s;
    cfg_dst_i <= d;
    cfg_count_i <= n;
    cfg_trig_i <= tr;
    cfg_be_i <= be_v;
    dmem_cache_i <= cache_v;
    pmem_plain_mode_i <= plain_v;
    cfg_load_i <= 4'h1 << ch;
    @(posedge sys_clk_i);
    cfg_load_i <= 4'h0;
  endtask : load
  // w: 0 done or err bits, 1 boot done, 2 write strobe
  task automatic wait_st(input logic [3:0] m, input int w);
    int i;
    logic [3:0] v;
    for (i = 0; i < 5000; i++) begin
      @(negedge sys_clk_i);
      v = (w == 1) ? {3'h0, boot_done_o} : (w == 2) ? {3'h0, bus_wr_o} : ch_done_o | ch_err_o;
      if ((v & m) === m) break;
    end
    if (i == 5000) begin
      mismatches++;
      $display("Error wait expected %h seen %h", m, v & m);
      end_sim();
    end
  endtask : wait_st
  task automatic t_boot();
    wait_st(4'h1, 1);
    chk("boot_first", 32'hC1C3_0000, mem_u.mem[32'h0000_0000]);
    chk("boot_last", 32'hC1C3_03FC, mem_u.mem[32'h0000_03FC]);
  endtask : t_boot
  task automatic t_copy();
    mem_u.dly = 3;
    load(1, 32'h0300_0000, 32'h8000_0100, 16'h0003, fcd_pkg::TRIG_NONE);
    wait_st(4'h2, 0);
    for (int k = 0; k < 3; k++)
      chk("copy", 32'hC0C3_0000 + 4 * k, mem_u.mem[32'h8000_0100 + 4 * k]);
    chk("done", 32'h0000_0002, {28'h000_0000, ch_done_o & 4'h2});
    chk("busy", 32'h0000_0000, {28'h000_0000, ch_busy_o});
    mem_u.dly = 0;
  endtask : t_copy
  task automatic t_lanes();
    be_v = 4'h3;
    load(2, 32'h0300_0040, 32'h0400_0000, 16'h0001, fcd_pkg::TRIG_NONE);
    wait_st(4'h4, 0);
    chk("lanes", 32'h0000_0040, mem_u.mem[32'h0400_0000]);
    be_v = 4'hF;
  endtask : t_lanes
  task automatic t_bad();
    logic [31:0] bs [4] = '{32'h0000_0000, 32'h0300_0000, 32'h0300_0000, 32'h0300_0000};
    logic [31:0] bd [4] = '{32'h8000_0000, 32'h0100_0000, 32'h8000_0000, 32'h0000_0100};
    for (int k = 0; k < 4; k++) begin
      cache_v = (k == 2);
      plain_v = (k != 3);
      load(0, bs[k], bd[k], 16'h0001, fcd_pkg::TRIG_NONE);
      wait_st(4'h1, 0);
      chk("err", 32'h0000_0001, {28'h000_0000, ch_err_o & 4'h1});
      chk("nodone", 32'h0000_0000, {28'h000_0000, ch_done_o & 4'h1});
    end
    cache_v = 1'h0;
    plain_v = 1'h1;
  endtask : t_bad
  task automatic t_trig();
    for (int md = 1; md < 4; md++) begin
      load(md, 32'h0300_0100, 32'h8000_0400 + 4 * md, 16'h0001, 2'(md));
      repeat (3) @(negedge sys_clk_i);
      chk("held", 32'h0000_0000, {31'h0000_0000, bus_rd_o});
      @(posedge sys_clk_i);
      ser_rx_evt_i <= (md == 1) ? 2'h2 : 2'h0;
      ser_tx_evt_i <= (md == 2) ? 2'h2 : 2'h0;
      timer_evt_i <= (md == 3) ? 2'h2 : 2'h0;
      @(posedge sys_clk_i);
      {ser_rx_evt_i, ser_tx_evt_i, timer_evt_i} <= 6'h00;
      wait_st(4'h1 << md, 0);
      chk("trig", 32'hC0C3_0100, mem_u.mem[32'h8000_0400 + 4 * md]);
    end
  endtask : t_trig
  task automatic t_prio();
    load(3, 32'h0300_0080, 32'h8000_0300, 16'h0001, fcd_pkg::TRIG_TIMER);
    load(1, 32'h0300_0080, 32'h8000_0200, 16'h0001, fcd_pkg::TRIG_TIMER);
    @(posedge sys_clk_i);
    timer_evt_i <= 2'h1;
    @(posedge sys_clk_i);
    timer_evt_i <= 2'h0;
    wait_st(4'h1, 2);
    chk("first", 32'h8000_0200, bus_addr_o);
    wait_st(4'h2, 0);
    @(posedge sys_clk_i);
    timer_evt_i <= 2'h1;
    @(posedge sys_clk_i);
    timer_evt_i <= 2'h0;
    wait_st(4'h8, 0);
    chk("second", 32'hC0C3_0080, mem_u.mem[32'h8000_0300]);
  endtask : t_prio
  // Eight words through the fetch buffer inside the design, slow reads
  task automatic t_fifo();
    mem_u.dly = 2;
    load(2, 32'h0300_0200, 32'h8000_0800, 16'h0008, fcd_pkg::TRIG_NONE);
    wait_st(4'h4, 0);
    for (int k = 0; k < 8; k++)
      chk("fifo", 32'hC0C3_0200 + 4 * k, mem_u.mem[32'h8000_0800 + 4 * k]);
    mem_u.dly = 0;
  endtask : t_fifo
  initial begin
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'h0;
    t_boot();
    t_copy();
    t_lanes();
    t_bad();
    t_trig();
    t_prio();
    t_fifo();
    end_sim();
  end
endmodule : fcd_dma_tb
